/* bench/cri_mem_model.sv */
`timescale 1ns/1ps
// Byte memory on the far side of the core's read-modify-write bus.
module cri_mem_model (
  // Clock.
  input wire logic aclk,
  // Memory bus from the core.
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [15:0] last_a;
  logic [7:0] last_d;
  initial mem_rdata = 8'h00;
  // Data is valid only the cycle after a read; otherwise the bus toggles.
  always @(posedge aclk) begin
    mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
      last_a <= mem_addr;
      last_d <= mem_wdata;
    end
  end
endmodule : cri_mem_model

/* bench/test_cpu_core_regs_incdec_alu.sv */
`timescale 1ns/1ps
`include "cri_map.svh"
module test_cpu_core_regs_incdec_alu;
  import cri_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, fetch_byte, op_start, op_pair;
  logic op_busy, op_done, mem_rd, mem_wr;
  logic [7:0] awaddr, araddr, op_disp, cflags, mem_rdata, mem_wdata;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [15:0] fcnt, sp, mem_addr;
  cri_op_t op_sel;
  int mismatches, checks_done;
  // Core under test and its memory.
  cri_core u_cri_core (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fetch_byte(fetch_byte),
    .op_start(op_start), .op_sel(op_sel), .op_disp(op_disp),
    .op_pair(op_pair), .op_busy(op_busy), .op_done(op_done),
    .condition_flags(cflags), .fetch_counter(fcnt), .stack_top_pointer(sp),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  cri_mem_model u_cri_mem_model (.aclk(aclk), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata));
  // Prints the counts and the verdict, then stops.
  task automatic complete_run;
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, exp, input string m);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h", $time, m, got);
    end
  endtask : chk
  // Write cycle; waits for the answer, a hang is left to the watchdog.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  // Read cycle; data and response are taken at the answering edge.
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk(r, `CRI_RESP_OKAY, "write response");
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(d, e, "read data");
    chk(r, `CRI_RESP_OKAY, "read response");
  endtask : rd_chk
  // Starts one operation and times it from the taking edge.
  task automatic run_op(input cri_op_t o, input logic [7:0] dsp,
      input int n_exp, input logic [7:0] f_exp);
    int n;
    n = 0;
    @(posedge aclk);
    op_sel <= o;
    op_disp <= dsp;
    op_start <= 1'b1;
    @(posedge aclk);
    op_start <= 1'b0;
    do begin
      @(negedge aclk);
      n++;
      if (n == 1) chk(op_busy, 1'b1, "busy after start");
    end while (op_done !== 1'b1 && n < 40);
    chk(n, n_exp, "operation length");
    chk(cflags, f_exp, "flags after operation");
  endtask : run_op
  task automatic mem_chk(input logic [15:0] a, input logic [7:0] d);
    chk(u_cri_mem_model.last_a, a, "written address");
    chk(u_cri_mem_model.last_d, d, "written byte");
  endtask : mem_chk
  task automatic t_reset;
    rd_chk(`CRI_OFS_FETCH, 32'h0);
    rd_chk(`CRI_OFS_STACK, 32'h0);
    rd_chk(`CRI_OFS_FLAGS, 32'h0);
  endtask : t_reset
  task automatic t_fetch;
    @(posedge aclk);
    fetch_byte <= 1'b1;
    repeat (3) @(posedge aclk);
    fetch_byte <= 1'b0;
    @(negedge aclk);
    chk(fcnt, 16'h0003, "fetch counter port");
    rd_chk(`CRI_OFS_FETCH, 32'h3);
  endtask : t_fetch
  task automatic t_pair;
    u_cri_mem_model.mem[16'h1234] = 8'h80;
    wr(`CRI_OFS_FLAGS, 32'h01);
    wr(`CRI_OFS_PAIR, 32'h1234);
    run_op(CRI_OP_DEC_PAIR, 8'h00, 10, 8'h17);
    rd_chk(`CRI_OFS_FLAGS, 32'h17);
    mem_chk(16'h1234, 8'h7F);
    run_op(CRI_OP_INC_PAIR, 8'h00, 10, 8'h95);
    @(negedge aclk);
    mem_chk(16'h1234, 8'h80);
  endtask : t_pair
  task automatic t_idx;
    u_cri_mem_model.mem[16'h0FFE] = 8'hFF;
    u_cri_mem_model.mem[16'h2005] = 8'h01;
    wr(`CRI_OFS_IDX1, 32'h1000);
    wr(`CRI_OFS_IDX2, 32'h2000);
    run_op(CRI_OP_INC_IDX1, 8'hFE, 18, 8'h51);
    @(negedge aclk);
    mem_chk(16'h0FFE, 8'h00);
    run_op(CRI_OP_DEC_IDX2, 8'h05, 18, 8'h43);
    @(negedge aclk);
    mem_chk(16'h2005, 8'h00);
  endtask : t_idx
  task automatic t_prod;
    wr(`CRI_OFS_PAIR, 32'h0C0A);
    run_op(CRI_OP_PRODUCT, 8'h00, 17, 8'h43);
    rd_chk(`CRI_OFS_PAIR, 32'h0078);
    wr(`CRI_OFS_PROD, 32'h0305);
    op_pair <= 1'b1;
    run_op(CRI_OP_PRODUCT, 8'h00, 17, 8'h43);
    rd_chk(`CRI_OFS_PROD, 32'h000F);
    op_pair <= 1'b0;
    rd_chk(`CRI_OFS_PAIR, 32'h0078);
    rd_chk(`CRI_OFS_STATUS, 32'h0000000C);
  endtask : t_prod
  task automatic t_bad;
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(8'h20, d, r);
    chk(r, `CRI_RESP_SLVERR, "unmapped read");
    axi_wr(8'h20, 32'h1, r);
    chk(r, `CRI_RESP_SLVERR, "unmapped write");
    wr(`CRI_OFS_FLAGS, 32'hFF);
    rd_chk(`CRI_OFS_FLAGS, 32'hD7);
  endtask : t_bad
  task automatic t_rst2;
    wr(`CRI_OFS_STACK, 32'h5555);
    wr(`CRI_OFS_FETCH, 32'hAAAA);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    chk(sp, 16'h0000, "stack pointer in reset");
    chk(fcnt, 16'h0000, "fetch counter in reset");
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd_chk(`CRI_OFS_STACK, 32'h0);
    rd_chk(`CRI_OFS_FETCH, 32'h0);
  endtask : t_rst2
  // Clock at 25 MHz.
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Cuts a hang short.
  initial begin
    #400000;
    $display("unexpected at %0t: watchdog expired", $time);
    mismatches++;
    complete_run();
  end
  // Main sequence.
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {fetch_byte, op_start, op_pair, aresetn} = '0;
    {awaddr, araddr, op_disp, wdata, wstrb} = '0;
    op_sel = CRI_OP_NONE;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_fetch();
    t_pair();
    t_idx();
    t_prod();
    t_bad();
    t_rst2();
    complete_run();
  end
endmodule : test_cpu_core_regs_incdec_alu

/* rtl/cri_alu.sv */
`timescale 1ns/1ps
`include "cri_map.svh"
module cri_alu (
  // Operand and operation.
  input wire logic [7:0] opnd,
  input wire logic dec,
  input wire logic [7:0] flags_in,
  // Result and new flags.
  output logic [7:0] result,
  output logic [7:0] flags_out
);
  import cri_pkg::*;

  // Plus or minus one with the flag effects; carry is kept as it was.
  always_comb begin
    result = dec ? opnd - 8'h01 : opnd + 8'h01;
    flags_out = flags_in & `CRI_F_MASK;
    flags_out[`CRI_F_S] = result[7];
    flags_out[`CRI_F_Z] = (result == 8'h00);
    flags_out[`CRI_F_H] = dec ? (opnd[3:0] == 4'h0) : (opnd[3:0] == 4'hF);
    flags_out[`CRI_F_V] = dec ? (opnd == 8'h80) : (opnd == 8'h7F);
    flags_out[`CRI_F_N] = dec;
  end

endmodule : cri_alu

/* rtl/cri_core.sv */
`timescale 1ns/1ps
`include "cri_map.svh"
// Contract
// - Stack top pointer is forced to zero while reset is held.
// - Fetch counter is forced to zero during reset.
// - Fetch counter advances by one after every instruction byte fetch, except a fetch in the cycle of a software write to it.
// - Flags hold result status and are offered to program flow.
// - Sign flag, bit 7, copies the result's top bit.
// - Decrement byte at pair pointer in 10 states; N set, C kept.
// - Increment byte at pair pointer in 10 states; N clear, C kept.
// - Indexed increment or decrement completes in 18 states.
module cri_core (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Instruction decoder side.
  input wire logic fetch_byte,
  input wire logic op_start,
  input wire cri_pkg::cri_op_t op_sel,
  input wire logic [7:0] op_disp,
  input wire logic op_pair,
  output logic op_busy,
  output logic op_done,
  output logic [7:0] condition_flags,
  output logic [15:0] fetch_counter,
  output logic [15:0] stack_top_pointer,
  // Memory bus; read data is valid the cycle after mem_rd.
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata
);
  import cri_pkg::*;

  cri_st_t st_ff;
  cri_st_t nxt_st;
  logic pc_sw_wr;
  logic [7:0] alu_res;
  logic [7:0] alu_flags;
  logic [15:0] mul_src;
  logic [15:0] mul_res;

  // Plus or minus one unit; odd op codes are decrements.
  cri_alu u_alu (
    .opnd(mem_rdata),
    .dec(st_ff.op[0]),
    .flags_in(st_ff.f),
    .result(alu_res),
    .flags_out(alu_flags)
  );

  // Byte product of the chosen pair.
  assign mul_src = st_ff.use_prod ? st_ff.prod : st_ff.hl;
  assign mul_res = {8'h00, mul_src[15:8]} * {8'h00, mul_src[7:0]};

  // Next state: bus slave, fetch counter and operation sequencer.
  always_comb begin
    nxt_st = st_ff;
    pc_sw_wr = 1'b0;
    nxt_st.done = 1'b0;
    nxt_st.mrd = 1'b0;
    nxt_st.mwr = 1'b0;
    if (s_axi_awvalid && st_ff.awready) begin
      nxt_st.awok = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.wready) begin
      nxt_st.wok = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.awok && st_ff.wok && !st_ff.bvalid) begin
      nxt_st.awok = 1'b0;
      nxt_st.wok = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = `CRI_RESP_OKAY;
      case (st_ff.awaddr)
        `CRI_OFS_FETCH: begin
          nxt_st.pc = cri_merge(st_ff.pc, st_ff.wdata, st_ff.wstrb);
          pc_sw_wr = 1'b1;
        end
        `CRI_OFS_STACK: nxt_st.sp = cri_merge(st_ff.sp, st_ff.wdata,
            st_ff.wstrb);
        `CRI_OFS_FLAGS: begin
          if (st_ff.wstrb[0]) begin
            nxt_st.f = st_ff.wdata[7:0] & `CRI_F_MASK;
          end
        end
        `CRI_OFS_PAIR: nxt_st.hl = cri_merge(st_ff.hl, st_ff.wdata,
            st_ff.wstrb);
        `CRI_OFS_IDX1: nxt_st.ix = cri_merge(st_ff.ix, st_ff.wdata,
            st_ff.wstrb);
        `CRI_OFS_IDX2: nxt_st.iy = cri_merge(st_ff.iy, st_ff.wdata,
            st_ff.wstrb);
        `CRI_OFS_PROD: nxt_st.prod = cri_merge(st_ff.prod, st_ff.wdata,
            st_ff.wstrb);
        `CRI_OFS_STATUS: nxt_st.bresp = `CRI_RESP_OKAY;
        default: nxt_st.bresp = `CRI_RESP_SLVERR;
      endcase
    end
    nxt_st.awready = !nxt_st.awok && !nxt_st.bvalid;
    nxt_st.wready = !nxt_st.wok && !nxt_st.bvalid;
    // Read channel; the answer shows the block's live registers.
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_ff.arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = `CRI_RESP_OKAY;
      case (s_axi_araddr)
        `CRI_OFS_FETCH: nxt_st.rdata = {16'h0000, st_ff.pc};
        `CRI_OFS_STACK: nxt_st.rdata = {16'h0000, st_ff.sp};
        `CRI_OFS_FLAGS: nxt_st.rdata = {24'h000000, st_ff.f};
        `CRI_OFS_PAIR: nxt_st.rdata = {16'h0000, st_ff.hl};
        `CRI_OFS_IDX1: nxt_st.rdata = {16'h0000, st_ff.ix};
        `CRI_OFS_IDX2: nxt_st.rdata = {16'h0000, st_ff.iy};
        `CRI_OFS_PROD: nxt_st.rdata = {16'h0000, st_ff.prod};
        `CRI_OFS_STATUS: nxt_st.rdata = {28'h0000000, st_ff.op,
            st_ff.busy};
        default: begin
          nxt_st.rdata = 32'h00000000;
          nxt_st.rresp = `CRI_RESP_SLVERR;
        end
      endcase
    end
    nxt_st.arready = !nxt_st.rvalid;
    // A software write to the counter takes the place of that fetch.
    if (fetch_byte && !pc_sw_wr) begin
      nxt_st.pc = st_ff.pc + 16'h0001;
    end
    // Operation sequencer; a start while busy is ignored.
    case (st_ff.state)
      CRI_IDLE: begin
        if (op_start && op_sel != CRI_OP_NONE) begin
          nxt_st.state = CRI_RUN;
          nxt_st.busy = 1'b1;
          nxt_st.op = op_sel;
          nxt_st.use_prod = op_pair;
          case (op_sel)
            CRI_OP_INC_PAIR, CRI_OP_DEC_PAIR: begin
              nxt_st.cnt = `CRI_PAIR_STATES - 5'h01;
              nxt_st.maddr = st_ff.hl;
            end
            CRI_OP_INC_IDX1, CRI_OP_DEC_IDX1: begin
              nxt_st.cnt = `CRI_IDX_STATES - 5'h01;
              nxt_st.maddr = st_ff.ix + {{8{op_disp[7]}}, op_disp};
            end
            CRI_OP_INC_IDX2, CRI_OP_DEC_IDX2: begin
              nxt_st.cnt = `CRI_IDX_STATES - 5'h01;
              nxt_st.maddr = st_ff.iy + {{8{op_disp[7]}}, op_disp};
            end
            default: nxt_st.cnt = `CRI_MUL_STATES - 5'h01;
          endcase
        end
      end
      CRI_RUN: begin
        nxt_st.cnt = st_ff.cnt - 5'h01;
        if (st_ff.cnt == 5'h03 && st_ff.op != CRI_OP_PRODUCT) begin
          nxt_st.mrd = 1'b1;
        end
        if (st_ff.cnt == 5'h01) begin
          nxt_st.state = CRI_IDLE;
          nxt_st.busy = 1'b0;
          nxt_st.done = 1'b1;
          if (st_ff.op == CRI_OP_PRODUCT) begin
            if (st_ff.use_prod) begin
              nxt_st.prod = mul_res;
            end else begin
              nxt_st.hl = mul_res;
            end
          end else begin
            nxt_st.mwr = 1'b1;
            nxt_st.mwdata = alu_res;
            nxt_st.f = alu_flags;
          end
        end
      end
      default: begin
        nxt_st.state = CRI_IDLE;
        nxt_st.busy = 1'b0;
      end
    endcase
  end

  // State register with synchronous reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.state <= CRI_IDLE;
      st_ff.op <= CRI_OP_NONE;
      st_ff.pc <= `CRI_RST_16;
      st_ff.sp <= `CRI_RST_16;
      st_ff.f <= `CRI_RST_FLAGS;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register.
  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready = st_ff.wready;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign op_busy = st_ff.busy;
  assign op_done = st_ff.done;
  assign condition_flags = st_ff.f;
  assign fetch_counter = st_ff.pc;
  assign stack_top_pointer = st_ff.sp;
  assign mem_addr = st_ff.maddr;
  assign mem_rd = st_ff.mrd;
  assign mem_wr = st_ff.mwr;
  assign mem_wdata = st_ff.mwdata;

  // Checks on reset values, counter stepping and operation timing.
  chk_sp_reset: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> st_ff.sp == 16'h0000)
    else $error("stack pointer not zero after reset");
  chk_pc_reset: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> st_ff.pc == 16'h0000)
    else $error("fetch counter not zero after reset");
  chk_pc_step: assert property (@(posedge aclk) disable iff (!aresetn)
      fetch_byte && !pc_sw_wr |=> st_ff.pc == $past(st_ff.pc) + 16'h0001)
    else $error("fetch counter did not advance");
  chk_sign_copy: assert property (@(posedge aclk) disable iff (!aresetn)
      st_ff.done && st_ff.op != CRI_OP_PRODUCT |->
      st_ff.f[7] == st_ff.mwdata[7])
    else $error("sign flag differs from result bit 7");
  chk_rmw_value: assert property (
      @(posedge aclk) disable iff (!aresetn)
      st_ff.done && st_ff.op != CRI_OP_PRODUCT |->
      st_ff.mwdata == (st_ff.op[0] ? $past(mem_rdata) - 8'h01 :
      $past(mem_rdata) + 8'h01))
    else $error("written byte is not the read byte plus or minus one");
  chk_pair_dec: assert property (@(posedge aclk) disable iff (!aresetn)
      op_start && st_ff.state == CRI_IDLE && op_sel == CRI_OP_DEC_PAIR |->
      ##10 (st_ff.done && st_ff.mwr && st_ff.f[1]))
    else $error("pair decrement not done in 10 states");
  chk_pair_inc: assert property (@(posedge aclk) disable iff (!aresetn)
      op_start && st_ff.state == CRI_IDLE && op_sel == CRI_OP_INC_PAIR |->
      ##10 (st_ff.done && st_ff.mwr && !st_ff.f[1]))
    else $error("pair increment not done in 10 states");
  chk_index_time: assert property (@(posedge aclk) disable iff (!aresetn)
      op_start && st_ff.state == CRI_IDLE && op_sel != CRI_OP_NONE &&
      op_sel != CRI_OP_PRODUCT && op_sel[2:1] != 2'b00 |->
      ##18 (st_ff.done && st_ff.mwr))
    else $error("indexed operation not done in 18 states");
  chk_product: assert property (@(posedge aclk) disable iff (!aresetn)
      op_start && st_ff.state == CRI_IDLE && op_sel == CRI_OP_PRODUCT |->
      ##17 (st_ff.done && !st_ff.mwr && st_ff.f == $past(st_ff.f, 17)))
    else $error("product not done in 17 states or flags moved");

endmodule : cri_core

/* rtl/cri_map.svh */
`ifndef CRI_MAP_SVH
`define CRI_MAP_SVH

// Register byte offsets on the AXI4-Lite bus.
`define CRI_OFS_FETCH 8'h00
`define CRI_OFS_STACK 8'h04
`define CRI_OFS_FLAGS 8'h08
`define CRI_OFS_PAIR 8'h0C
`define CRI_OFS_IDX1 8'h10
`define CRI_OFS_IDX2 8'h14
`define CRI_OFS_PROD 8'h18
`define CRI_OFS_STATUS 8'h1C

// Reset values.
`define CRI_RST_16 16'h0000
`define CRI_RST_FLAGS 8'h00

// Flag bit positions and the mask of implemented flag bits.
`define CRI_F_S 7
`define CRI_F_Z 6
`define CRI_F_H 4
`define CRI_F_V 2
`define CRI_F_N 1
`define CRI_F_C 0
`define CRI_F_MASK 8'hD7

// Operation lengths in clock states.
`define CRI_PAIR_STATES 5'h0A
`define CRI_IDX_STATES 5'h12
`define CRI_MUL_STATES 5'h11

// AXI responses.
`define CRI_RESP_OKAY 2'h0
`define CRI_RESP_SLVERR 2'h2

`endif

/* rtl/cri_pkg.sv */
package cri_pkg;

  // Sequencer states, one-hot.
  typedef enum logic [1:0] {
    CRI_IDLE = 2'b01,
    CRI_RUN = 2'b10
  } cri_state_t;

  // Operations that the decoder may request.
  typedef enum logic [2:0] {
    CRI_OP_INC_PAIR = 3'h0,
    CRI_OP_DEC_PAIR = 3'h1,
    CRI_OP_INC_IDX1 = 3'h2,
    CRI_OP_DEC_IDX1 = 3'h3,
    CRI_OP_INC_IDX2 = 3'h4,
    CRI_OP_DEC_IDX2 = 3'h5,
    CRI_OP_PRODUCT = 3'h6,
    CRI_OP_NONE = 3'h7
  } cri_op_t;

  // Whole state of the core block.
  typedef struct packed {
    cri_state_t state;
    cri_op_t op;
    logic use_prod;
    logic [4:0] cnt;
    logic busy;
    logic done;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] hl;
    logic [15:0] ix;
    logic [15:0] iy;
    logic [15:0] prod;
    logic [7:0] f;
    logic [15:0] maddr;
    logic mrd;
    logic mwr;
    logic [7:0] mwdata;
    logic awready;
    logic wready;
    logic awok;
    logic wok;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cri_st_t;

  // Merges the two low byte lanes of a write into a 16-bit register.
  function automatic logic [15:0] cri_merge(input logic [15:0] old,
      input logic [31:0] d, input logic [3:0] s);
    cri_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : cri_merge

endpackage : cri_pkg
